// ==== rtl/ssc_cfg.svh ====
// Constants of the serial synchronous controller: widths, depths, reset values.
// Included by the package and by the controller file; definitions only.
`ifndef SSC_CFG_SVH
`define SSC_CFG_SVH

`define SSC_DATA_W        32
`define SSC_WLEN_W        5
`define SSC_CNT_W         6
`define SSC_EDGE_W        7
`define SSC_DIV_W         8
`define SSC_FIFO_DEPTH    4
`define SSC_SYNC_PINS     3
`define SSC_WLEN_FULL     6'h20
`define SSC_RST_WORD      32'h0000_0000
`define SSC_RST_CNT       6'h00
`define SSC_RST_EDGE      7'h00
`define SSC_RST_DIV       8'h00
`define SSC_RST_PINS      3'h0

`endif

// ==== rtl/ssc_pkg.sv ====
// Types shared by the serial synchronous controller and its users.
// Assumes ssc_cfg.svh on the include path.
`include "ssc_cfg.svh"

package ssc_pkg;

  // Main control settings, held by the user side as plain levels
  typedef struct packed {
    logic                   controller_enable;
    logic                   slave_role;
    logic                   clock_idle_level;
    logic                   transmit_edge_select;
    logic                   receive_edge_select;
    logic                   lsb_first;
    logic [`SSC_WLEN_W-1:0] word_bit_length;
    logic                   word_done_irq_enable;
    logic                   byte_reorder;
    logic                   half_duplex;
    logic                   half_duplex_tx;
    logic                   receive_only;
    logic                   tx_dma_enable;
    logic                   rx_dma_enable;
    logic [`SSC_DIV_W-1:0]  clock_divisor;
  } ssc_ctrl_t;

  // Select line control
  typedef struct packed {
    logic select_active_level;
    logic automatic_select_enable;
    logic manual_select;
  } ssc_sel_t;

  // Status flags shown to software
  typedef struct packed {
    logic word_done_flag;
    logic busy;
    logic tx_full;
    logic tx_empty;
    logic rx_full;
    logic rx_empty;
  } ssc_status_t;

  // Master sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_DONE = 3'b100
  } ssc_state_t;

endpackage

// ==== rtl/ssc_spi_ctrl.sv ====
// Serial synchronous controller: master or slave on a four-wire link, with
// transmit and receive queues. Assumes ssc_pkg compiled first; the user side
// is on clock, the slave shifter runs on the external serial clock link_sclk.
`timescale 1ns/1ps
`include "ssc_cfg.svh"

// Queue of flip-flops addressed by read and write indices
module ssc_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 4
) (
  input  wire logic         clock,
  input  wire logic         reset_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;
  wire          push = in_valid & in_ready;
  wire          pop  = out_valid & out_ready;

  // Extra pointer bit tells full from empty
  assign in_ready  = (wr_q[AW] == rd_q[AW]) | (wr_q[AW-1:0] != rd_q[AW-1:0]);
  assign out_valid = (wr_q != rd_q);
  assign out_data  = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop)  rd_q <= rd_q + 1'b1;
    end
  end

  // Storage has no reset; contents are guarded by the pointers
  always_ff @(posedge clock) begin
    if (push) mem_q[wr_q[AW-1:0]] <= in_data;
  end
endmodule

// How it works
// - Select line active level follows select_active_level: 0 low, 1 high.
// - Serial clock rests at clock_idle_level between words.
// - Word length 1 to 32 bits from a five-bit field, zero meaning 32.
// - Bits leave and arrive MSB first, or LSB first when lsb_first set.
// - Edge selects pick which serial clock edge drives and which samples.
// - Role 0 makes clock and select, role 1 follows external ones.
// - Transmit and receive each have their own four-entry queue.
// - Master serial clock half period is divisor plus one system clocks.
// - Automatic select wraps transfers; when off, software owns the line.
// - Manual select bit drives the select output active or inactive.
// - No serial transfer happens while controller_enable is low.
// - Each finished word sets a sticky flag; enabled flag raises irq.
// - Written words queue for sending; received words queue for reading.
// - Slave shifts only under external select and external clock edges.
// - Slave with nothing new to send resends its held word, still receives.
// - Full duplex shifts one word out and one in at once.
// - Half duplex uses the single mosi line in one direction.
// - Receive-only captures words with no transmit data needed.
// - Byte reorder swaps bytes between queues and the serial line for 16, 24 and 32-bit words.
// - DMA request lines flag queue space and waiting received words.
module ssc_spi_ctrl #(
  parameter int DEPTH = `SSC_FIFO_DEPTH
) (
  input  wire logic                    clock,
  input  wire logic                    reset_n,
  input  wire logic                    link_sclk,
  input  wire ssc_pkg::ssc_ctrl_t      ctrl,
  input  wire ssc_pkg::ssc_sel_t       sel_cfg,
  input  wire logic                    word_done_clear,
  input  wire logic                    tx_wr,
  input  wire logic [`SSC_DATA_W-1:0]  tx_wdata,
  output logic                         tx_ready,
  input  wire logic                    rx_rd,
  output logic [`SSC_DATA_W-1:0]       rx_rdata,
  output logic                         rx_valid,
  output logic                         tx_dma_req,
  output logic                         rx_dma_req,
  output ssc_pkg::ssc_status_t         status,
  output logic                         irq,
  output logic                         sclk_out,
  output logic                         sclk_oe,
  input  wire logic                    select_in,
  output logic                         select_out,
  output logic                         select_oe,
  input  wire logic                    mosi_in,
  output logic                         mosi_out,
  output logic                         mosi_oe,
  input  wire logic                    miso_in,
  output logic                         miso_out,
  output logic                         miso_oe
);
  import ssc_pkg::*;

  // Byte order swap for multi-byte words
  function automatic logic [`SSC_DATA_W-1:0] reorder(input logic [`SSC_DATA_W-1:0] d,
                                                     input logic [`SSC_CNT_W-1:0]  w,
                                                     input logic                   en);
    logic [`SSC_DATA_W-1:0] r;
    r = d;
    if (en) begin
      unique case (w)
        6'h20:   r = {d[7:0], d[15:8], d[23:16], d[31:24]};
        6'h18:   r = {8'h00, d[7:0], d[15:8], d[23:16]};
        6'h10:   r = {16'h0000, d[7:0], d[15:8]};
        default: r = d;
      endcase
    end
    return r;
  endfunction

  // Decoded settings
  wire [`SSC_CNT_W-1:0] wlen = (ctrl.word_bit_length == 5'h00) ? `SSC_WLEN_FULL
                                : {1'b0, ctrl.word_bit_length};
  wire master_en = ctrl.controller_enable & ~ctrl.slave_role;
  wire slave_en  = ctrl.controller_enable &  ctrl.slave_role;
  wire need_tx   = ~(ctrl.receive_only | (ctrl.half_duplex & ~ctrl.half_duplex_tx));
  wire keep_rx   = ~(ctrl.half_duplex & ctrl.half_duplex_tx);

  // Queues and their hand-offs
  logic                   tx_pop;
  logic                   tx_has;
  logic [`SSC_DATA_W-1:0] tx_head;
  logic                   rx_push;
  logic                   rx_space;
  logic [`SSC_DATA_W-1:0] rx_push_data;

  ssc_fifo #(.W(`SSC_DATA_W), .DEPTH(DEPTH)) u_tx_fifo (
    .clock     (clock),
    .reset_n   (reset_n),
    .in_valid  (tx_wr),
    .in_ready  (tx_ready),
    .in_data   (tx_wdata),
    .out_valid (tx_has),
    .out_ready (tx_pop),
    .out_data  (tx_head)
  );

  ssc_fifo #(.W(`SSC_DATA_W), .DEPTH(DEPTH)) u_rx_fifo (
    .clock     (clock),
    .reset_n   (reset_n),
    .in_valid  (rx_push),
    .in_ready  (rx_space),
    .in_data   (rx_push_data),
    .out_valid (rx_valid),
    .out_ready (rx_rd),
    .out_data  (rx_rdata)
  );

  // DMA requests mirror queue state
  assign tx_dma_req = ctrl.tx_dma_enable & tx_ready;
  assign rx_dma_req = ctrl.rx_dma_enable & rx_valid;

  // Pin synchronisers: three stages, a change counts once stages two and three agree
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic [2:0] pin_s3_q;
  logic [2:0] pin_f_q;
  wire  [2:0] pin_raw = {select_in, mosi_in, miso_in};
  wire  [2:0] pin_agree = ~(pin_s2_q ^ pin_s3_q);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_q <= `SSC_RST_PINS;
      pin_s2_q <= `SSC_RST_PINS;
      pin_s3_q <= `SSC_RST_PINS;
      pin_f_q  <= `SSC_RST_PINS;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_f_q  <= (pin_agree & pin_s3_q) | (~pin_agree & pin_f_q);
    end
  end

  wire miso_f     = pin_f_q[0];
  wire mosi_f     = pin_f_q[1];
  wire sel_in_f   = pin_f_q[2];
  wire frame_sync = slave_en & (sel_in_f == sel_cfg.select_active_level);

  // Master sequencer on the system clock
  ssc_state_t             state_q;
  logic [`SSC_DIV_W-1:0]  div_q;
  logic [`SSC_EDGE_W-1:0] edge_q;
  logic [`SSC_CNT_W-1:0]  bit_tx_q;
  logic [`SSC_CNT_W-1:0]  bit_rx_q;
  logic                   sclk_q;
  logic                   mosi_q;
  logic [`SSC_DATA_W-1:0] mtx_q;
  logic [`SSC_DATA_W-1:0] mrx_q;

  wire m_start = master_en & (state_q == ST_IDLE) & rx_space
                 & (need_tx ? tx_has : 1'b1);
  wire m_tick  = (state_q == ST_RUN) & (div_q == ctrl.clock_divisor);
  wire m_rise  = ~sclk_q;
  wire m_drive = m_tick & (m_rise ^ ctrl.transmit_edge_select);
  wire m_samp  = m_tick & (m_rise ^ ctrl.receive_edge_select);
  wire m_last  = m_tick & (edge_q == 7'({1'b0, wlen, 1'b0} - 7'h01));
  wire m_rxbit = ctrl.half_duplex ? mosi_f : miso_f;
  wire [`SSC_CNT_W-1:0] m_tx_idx = ctrl.lsb_first ? bit_tx_q
                                   : 6'(wlen - 6'h01 - bit_tx_q);
  wire [`SSC_CNT_W-1:0] m_rx_idx = ctrl.lsb_first ? bit_rx_q
                                   : 6'(wlen - 6'h01 - bit_rx_q);
  wire m_bit = need_tx & mtx_q[m_tx_idx[4:0]];

  // Sequencer state; dropping enable aborts the word at once
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
    end else if (!master_en) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: if (m_start) state_q <= ST_RUN;
        ST_RUN:  if (m_last) state_q <= ST_DONE;
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Clock divider and edge counter
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      div_q  <= `SSC_RST_DIV;
      edge_q <= `SSC_RST_EDGE;
      sclk_q <= 1'b0;
    end else if (state_q != ST_RUN) begin
      div_q  <= `SSC_RST_DIV;
      edge_q <= `SSC_RST_EDGE;
      sclk_q <= ctrl.clock_idle_level;
    end else begin
      div_q  <= m_tick ? `SSC_RST_DIV : div_q + 8'h01;
      edge_q <= m_tick ? edge_q + 7'h01 : edge_q;
      sclk_q <= m_tick ? ~sclk_q : sclk_q;
    end
  end

  // Shift data: a drive edge on the leading edge of a word does not advance the pointer
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bit_tx_q <= `SSC_RST_CNT;
      bit_rx_q <= `SSC_RST_CNT;
      mtx_q    <= `SSC_RST_WORD;
      mrx_q    <= `SSC_RST_WORD;
      mosi_q   <= 1'b0;
    end else begin
      if (m_start) begin
        bit_tx_q <= `SSC_RST_CNT;
        bit_rx_q <= `SSC_RST_CNT;
        mtx_q    <= need_tx ? reorder(tx_head, wlen, ctrl.byte_reorder) : `SSC_RST_WORD;
        mrx_q    <= `SSC_RST_WORD;
      end else begin
        if (m_drive && edge_q != `SSC_RST_EDGE) bit_tx_q <= bit_tx_q + 6'h01;
        if (m_samp) begin
          mrx_q[m_rx_idx[4:0]] <= m_rxbit;
          bit_rx_q             <= bit_rx_q + 6'h01;
        end
      end
      mosi_q <= (state_q == ST_RUN) & m_bit;
    end
  end

  // Slave shifter on the external clock; a frame ends when select drops
  wire lk_frame_n = reset_n & slave_en
                    & (select_in == sel_cfg.select_active_level);
  wire rx_clk     = link_sclk ^ ctrl.receive_edge_select;
  wire tx_clk     = link_sclk ^ ctrl.transmit_edge_select;
  wire lead_drive = (ctrl.transmit_edge_select == ctrl.clock_idle_level);

  logic [`SSC_CNT_W-1:0]  lk_rx_cnt_q;
  logic [`SSC_DATA_W-1:0] lk_rx_sh_q;
  logic [`SSC_DATA_W-1:0] lk_hold_q;
  logic                   lk_tog_q;
  logic [`SSC_CNT_W-1:0]  lk_tx_cnt_q;
  logic                   lk_first_q;
  logic [`SSC_DATA_W-1:0] stx_q;

  wire [`SSC_CNT_W-1:0] lk_rx_idx = ctrl.lsb_first ? lk_rx_cnt_q
                                    : 6'(wlen - 6'h01 - lk_rx_cnt_q);
  wire [`SSC_CNT_W-1:0] lk_tx_idx = ctrl.lsb_first ? lk_tx_cnt_q
                                    : 6'(wlen - 6'h01 - lk_tx_cnt_q);
  wire lk_rx_end = (lk_rx_cnt_q == 6'(wlen - 6'h01));
  wire lk_tx_end = (lk_tx_cnt_q == 6'(wlen - 6'h01));
  wire [`SSC_DATA_W-1:0] lk_rx_word = lk_rx_sh_q | (32'(mosi_in) << lk_rx_idx[4:0]);

  // Receive side: bit count and partial word restart with each frame
  always_ff @(posedge rx_clk or negedge lk_frame_n) begin
    if (!lk_frame_n) begin
      lk_rx_cnt_q <= `SSC_RST_CNT;
      lk_rx_sh_q  <= `SSC_RST_WORD;
    end else begin
      lk_rx_cnt_q <= lk_rx_end ? `SSC_RST_CNT : lk_rx_cnt_q + 6'h01;
      lk_rx_sh_q  <= lk_rx_end ? `SSC_RST_WORD : lk_rx_word;
    end
  end

  // Finished word and its toggle survive the frame end for the crossing
  always_ff @(posedge rx_clk or negedge reset_n) begin
    if (!reset_n) begin
      lk_hold_q <= `SSC_RST_WORD;
      lk_tog_q  <= 1'b0;
    end else if (lk_frame_n && lk_rx_end) begin
      lk_hold_q <= lk_rx_word;
      lk_tog_q  <= ~lk_tog_q;
    end
  end

  // Transmit side pointer; a leading drive edge first presents bit zero
  always_ff @(posedge tx_clk or negedge lk_frame_n) begin
    if (!lk_frame_n) begin
      lk_tx_cnt_q <= `SSC_RST_CNT;
      lk_first_q  <= 1'b1;
    end else begin
      lk_first_q <= 1'b0;
      if (!(lk_first_q && lead_drive)) begin
        lk_tx_cnt_q <= lk_tx_end ? `SSC_RST_CNT : lk_tx_cnt_q + 6'h01;
      end
    end
  end

  // Outgoing bit reads stx_q, which only changes between words
  wire s_bit = need_tx & stx_q[lk_tx_idx[4:0]];

  // Word-done toggle crossing into the system clock
  logic tog_s1_q;
  logic tog_s2_q;
  logic tog_s3_q;
  logic tog_seen_q;
  logic stx_fresh_q;
  wire  s_done = (tog_s2_q == tog_s3_q) & (tog_s3_q != tog_seen_q);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tog_s1_q   <= 1'b0;
      tog_s2_q   <= 1'b0;
      tog_s3_q   <= 1'b0;
      tog_seen_q <= 1'b0;
    end else begin
      tog_s1_q   <= lk_tog_q;
      tog_s2_q   <= tog_s1_q;
      tog_s3_q   <= tog_s2_q;
      tog_seen_q <= s_done ? tog_s3_q : tog_seen_q;
    end
  end

  // Slave transmit word: loaded outside a frame when none is fresh, refilled once per finished word, else kept
  wire s_load = slave_en & need_tx & ~stx_fresh_q & tx_has & ~frame_sync;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stx_q       <= `SSC_RST_WORD;
      stx_fresh_q <= 1'b0;
    end else begin
      if (s_load || (s_done && slave_en && need_tx && tx_has)) begin
        stx_q <= reorder(tx_head, wlen, ctrl.byte_reorder);
      end
      if (s_done) stx_fresh_q <= tx_has & need_tx;
      else if (s_load) stx_fresh_q <= 1'b1;
    end
  end

  // Queue hand-offs: master start or slave refill pops, either done pushes
  wire m_push = (state_q == ST_DONE) & keep_rx;
  wire s_push = s_done & slave_en & keep_rx;
  assign tx_pop       = (m_start & need_tx) | s_load
                        | (s_done & slave_en & need_tx & tx_has);
  assign rx_push      = m_push | s_push;
  assign rx_push_data = reorder(m_push ? mrx_q : lk_hold_q, wlen, ctrl.byte_reorder);

  // Sticky word-done flag; a new event beats a clear in the same cycle
  logic done_flag_q;
  wire  word_event = (state_q == ST_DONE) | (s_done & slave_en);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      done_flag_q <= 1'b0;
    end else begin
      done_flag_q <= word_event | (done_flag_q & ~word_done_clear);
    end
  end

  assign irq = done_flag_q & ctrl.word_done_irq_enable;

  assign status = '{word_done_flag: done_flag_q,
                    busy:           (state_q != ST_IDLE) | frame_sync,
                    tx_full:        ~tx_ready,
                    tx_empty:       ~tx_has,
                    rx_full:        ~rx_space,
                    rx_empty:       ~rx_valid};

  // Select line: automatic around master words, otherwise manual
  wire sel_assert = sel_cfg.automatic_select_enable
                    ? (state_q != ST_IDLE)
                    : sel_cfg.manual_select;
  assign select_out = sel_assert ? sel_cfg.select_active_level
                                 : ~sel_cfg.select_active_level;
  assign select_oe  = ~ctrl.slave_role;

  // Pin drivers per role and duplex option
  wire half_rx = ctrl.half_duplex & ~ctrl.half_duplex_tx;
  assign sclk_out = ctrl.slave_role ? ctrl.clock_idle_level : sclk_q;
  assign sclk_oe  = ~ctrl.slave_role;
  assign mosi_out = ctrl.slave_role ? s_bit : mosi_q;
  assign mosi_oe  = ctrl.slave_role ? (ctrl.half_duplex & ctrl.half_duplex_tx & lk_frame_n)
                                    : ~half_rx;
  assign miso_out = s_bit;
  assign miso_oe  = lk_frame_n & ~ctrl.half_duplex;
endmodule

// ==== tb/ssc_spi_ctrl_properties.sv ====
// Port checker for ssc_spi_ctrl, bound to every instance.
// Assumes all user-side logic runs on clock with async active-low reset_n.
`timescale 1ns/1ps
module ssc_spi_ctrl_properties (
  input wire logic                 clock,
  input wire logic                 reset_n,
  input wire ssc_pkg::ssc_ctrl_t   ctrl,
  input wire ssc_pkg::ssc_sel_t    sel_cfg,
  input wire ssc_pkg::ssc_status_t status,
  input wire logic                 tx_ready,
  input wire logic                 rx_valid,
  input wire logic                 tx_dma_req,
  input wire logic                 rx_dma_req,
  input wire logic                 irq,
  input wire logic                 sclk_out,
  input wire logic                 sclk_oe,
  input wire logic                 select_in,
  input wire logic                 select_out,
  input wire logic                 select_oe,
  input wire logic                 miso_oe
);
  import ssc_pkg::*;
  logic       last_q;
  logic [9:0] gap_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Cycles since the serial clock moved; saturates so long idle gaps never wrap
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      last_q <= 1'b0;
      gap_q  <= 10'h3ff;
    end else begin
      last_q <= sclk_out;
      gap_q  <= (sclk_out != last_q) ? 10'h000 : gap_q + {9'h000, gap_q != 10'h3ff};
    end
  end
  a_idle_clk_level: assert property ((!ctrl.controller_enable && !ctrl.slave_role && $stable(ctrl))[*3]
    |-> sclk_out == ctrl.clock_idle_level) else $error("serial clock not at idle level");
  a_manual_select: assert property (!ctrl.slave_role && !sel_cfg.automatic_select_enable
    |-> select_out == ~(sel_cfg.manual_select ^ sel_cfg.select_active_level)) else $error("select level wrong");
  a_half_period: assert property (!ctrl.slave_role && ctrl.controller_enable && sclk_out != last_q
    |-> gap_q >= {2'b00, ctrl.clock_divisor}) else $error("serial clock half period too short");
  a_off_no_word: assert property (!ctrl.controller_enable [*8]
    |-> !$rose(status.word_done_flag)) else $error("word finished while disabled");
  a_irq_follows: assert property (irq == (status.word_done_flag && ctrl.word_done_irq_enable))
    else $error("irq does not follow flag");
  a_done_has_rx: assert property ($rose(status.word_done_flag) && !ctrl.half_duplex
    |-> ##[0:2] rx_valid) else $error("finished word not readable");
  a_role_drive: assert property ($stable(ctrl.slave_role)
    |-> sclk_oe == !ctrl.slave_role && select_oe == !ctrl.slave_role) else $error("role drive wrong");
  a_slave_quiet: assert property ((ctrl.slave_role && select_in != sel_cfg.select_active_level)[*2]
    |-> !miso_oe) else $error("slave drives while unselected");
  a_dma_levels: assert property (tx_dma_req == (ctrl.tx_dma_enable && tx_ready)
    && rx_dma_req == (ctrl.rx_dma_enable && rx_valid)) else $error("dma request wrong");
  c_master_word: cover property ($rose(status.word_done_flag) && !ctrl.slave_role);
  c_slave_word: cover property ($rose(status.word_done_flag) && ctrl.slave_role);
  c_tx_full: cover property (!tx_ready);
endmodule
bind ssc_spi_ctrl ssc_spi_ctrl_properties u_ssc_spi_ctrl_properties (.clock, .reset_n, .ctrl, .sel_cfg, .status,
  .tx_ready, .rx_valid, .tx_dma_req, .rx_dma_req, .irq, .sclk_out, .sclk_oe, .select_in, .select_out, .select_oe,
  .miso_oe);

// ==== tb/ssc_spi_peer.sv ====
// Off-chip partner: serial slave while the controller is master, and serial
// master with a 64 ns link clock while it is slave. Sees resolved wires.
`timescale 1ns/1ps
module ssc_spi_peer (
  input  wire logic sclk,
  input  wire logic sel,
  input  wire logic act,
  input  wire logic mosi,
  input  wire logic miso,
  output logic      s_miso,
  output logic      m_sclk,
  output logic      m_sel,
  output logic      m_mosi
);
  logic [31:0] s_tx = 32'h0;
  logic [31:0] s_rx = 32'h0;
  int          s_idx = 0;
  int          s_n = 8;
  initial begin
    m_sclk = 1'b0;
    m_sel  = 1'b0;
    m_mosi = 1'b0;
  end
  // Slave side: sample on rise, next bit on fall, MSB first, wraps per word
  always @(posedge sclk) if (sel === act) s_rx = {s_rx[30:0], mosi};
  always @(negedge sclk) if (sel === act) s_idx = (s_idx == 0) ? s_n - 1 : s_idx - 1;
  // Unselected line shows the inverse so a stale bit cannot pass
  assign s_miso = (sel === act) ? s_tx[s_idx] : ~s_tx[s_idx];
  // One frame as master, LSB first; clock stands low outside frames
  task automatic frame(input logic [31:0] w, input int n, input logic on, output logic [31:0] got);
    got = 32'h0;
    m_sel = on ? act : ~act;
    #40;
    for (int i = 0; i < n; i++) begin
      m_mosi = w[i];
      #32 m_sclk = 1'b1;
      got[i] = miso;
      #32 m_sclk = 1'b0;
    end
    #40 m_sel = ~act;
    m_mosi = ~w[n-1];
  endtask
endmodule

// ==== tb/ssc_spi_ctrl_test.sv ====
// Self-checking bench: controller as master and as slave against ssc_spi_peer.
// Assumes ssc_pkg, the controller, its checker and the peer compiled first.
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin err_count++; \
  $display("BAD %s expected %h seen %h", n, e, a); end end
module ssc_spi_ctrl_test;
  import ssc_pkg::*;
  logic        clock, reset_n, word_done_clear, tx_wr, rx_rd, tx_ready, rx_valid, irq;
  logic        sclk_out, sclk_oe, select_out, select_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic        s_miso, m_sclk, m_sel, m_mosi, tx_dma_req, rx_dma_req;
  logic [31:0] tx_wdata, rx_rdata;
  ssc_ctrl_t   ctrl;
  ssc_sel_t    sel_cfg;
  ssc_status_t status;
  int          err_count = 0;
  int          compares = 0;
  // Wire levels resolved from the controller's enables, else the peer's outputs
  wire sclk_w = sclk_oe ? sclk_out : m_sclk;
  wire sel_w  = select_oe ? select_out : m_sel;
  wire mosi_w = mosi_oe ? mosi_out : m_mosi;
  wire miso_w = miso_oe ? miso_out : s_miso;
  ssc_spi_ctrl u_ssc_spi_ctrl (.clock, .reset_n, .link_sclk(sclk_w), .ctrl, .sel_cfg, .word_done_clear, .tx_wr,
    .tx_wdata, .tx_ready, .rx_rd, .rx_rdata, .rx_valid, .tx_dma_req, .rx_dma_req, .status, .irq, .sclk_out,
    .sclk_oe, .select_in(sel_w), .select_out, .select_oe, .mosi_in(mosi_w), .mosi_out, .mosi_oe,
    .miso_in(miso_w), .miso_out, .miso_oe);
  ssc_spi_peer u_ssc_spi_peer (.sclk(sclk_w), .sel(sel_w), .act(sel_cfg.select_active_level), .mosi(mosi_w),
    .miso(miso_w), .s_miso, .m_sclk, .m_sel, .m_mosi);
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic step(input int n = 1);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task automatic push(input logic [31:0] d);
    tx_wr = 1'b1;
    tx_wdata = d;
    step();
    tx_wr = 1'b0;
    step();
  endtask
  task automatic pop(input string n, input logic [31:0] e);
    `CHK(n, e, rx_rdata)
    rx_rd = 1'b1;
    step();
    rx_rd = 1'b0;
    step();
  endtask
  // Bounded wait for a finished word, then clear its flag
  task automatic wait_flag();
    int k;
    k = 0;
    while (status.word_done_flag !== 1'b1 && k < 3000) begin
      step();
      k++;
    end
    `CHK("word done flag", 1'b1, status.word_done_flag)
    `CHK("irq", 1'b1, irq)
    word_done_clear = 1'b1;
    step();
    word_done_clear = 1'b0;
  endtask
  function automatic logic [31:0] rev(input logic [31:0] x, input int n);
    rev = 32'h0;
    for (int i = 0; i < n; i++) rev[i] = x[n-1-i];
  endfunction
  task automatic t_master(input logic [4:0] wl, input int n, input logic lsb, input logic [31:0] d, pd);
    logic [31:0] m;
    m = (n == 32) ? 32'hffff_ffff : (32'h1 << n) - 32'h1;
    ctrl.word_bit_length = wl;
    ctrl.lsb_first = lsb;
    u_ssc_spi_peer.s_tx = pd;
    u_ssc_spi_peer.s_n = n;
    u_ssc_spi_peer.s_idx = n - 1;
    ctrl.controller_enable = 1'b1;
    push(d);
    wait_flag();
    `CHK("peer got", lsb ? rev(d, n) : d & m, u_ssc_spi_peer.s_rx & m)
    pop("master rx", lsb ? rev(pd, n) : pd & m);
    ctrl.controller_enable = 1'b0;
  endtask
  task automatic t_queue();
    ctrl.word_bit_length = 5'h08;
    ctrl.lsb_first = 1'b0;
    u_ssc_spi_peer.s_tx = 32'ha5;
    u_ssc_spi_peer.s_n = 8;
    u_ssc_spi_peer.s_idx = 7;
    for (int i = 0; i < 4; i++) push(32'h11 * i);
    `CHK("tx ready when full", 1'b0, tx_ready)
    step(20);
    `CHK("flag while off", 1'b0, status.word_done_flag)
    ctrl.controller_enable = 1'b1;
    repeat (4) wait_flag();
    `CHK("rx full", 1'b1, status.rx_full)
    repeat (4) pop("queued rx", 32'ha5);
    `CHK("rx drained", 1'b0, rx_valid)
    `CHK("rx empty", 1'b1, status.rx_empty)
    ctrl.controller_enable = 1'b0;
  endtask
  task automatic t_rxonly();
    ctrl.clock_idle_level = 1'b1;
    sel_cfg.select_active_level = 1'b1;
    step(4);
    `CHK("idle clock high", 1'b1, sclk_out)
    `CHK("select active high", 1'b1, select_out)
    ctrl.clock_idle_level = 1'b0;
    sel_cfg.select_active_level = 1'b0;
    step(2); // Idle fall first
    ctrl.receive_only = 1'b1;
    u_ssc_spi_peer.s_tx = 32'h69;
    u_ssc_spi_peer.s_idx = 7;
    u_ssc_spi_peer.s_rx = 32'hffff_ffff;
    ctrl.controller_enable = 1'b1;
    wait_flag();
    ctrl.controller_enable = 1'b0;
    `CHK("data line held low", 8'h00, u_ssc_spi_peer.s_rx[7:0])
    pop("receive only word", 32'h69);
    ctrl.receive_only = 1'b0;
  endtask
  task automatic t_slave();
    logic [31:0] got;
    ctrl.slave_role = 1'b1;
    ctrl.lsb_first = 1'b1;
    sel_cfg.select_active_level = 1'b1;
    ctrl.controller_enable = 1'b1;
    push(32'h96);
    u_ssc_spi_peer.frame(32'h5b, 8, 1'b0, got);
    step(10);
    `CHK("edges unselected", 1'b0, status.word_done_flag)
    u_ssc_spi_peer.frame(32'h5b, 8, 1'b1, got);
    wait_flag();
    `CHK("slave sent", 32'h96, got)
    pop("slave rx", 32'h5b);
    u_ssc_spi_peer.frame(32'h3c, 8, 1'b1, got);
    wait_flag();
    `CHK("slave resent", 32'h96, got)
    pop("slave rx again", 32'h3c);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Watchdog: the scenarios need a few thousand clocks at most
  initial begin
    #(10000 * 50);
    err_count++;
    stop_test();
  end
  initial begin
    reset_n = 1'b0;
    word_done_clear = 1'b0;
    tx_wr = 1'b0;
    rx_rd = 1'b0;
    tx_wdata = 32'h0;
    ctrl = '0;
    ctrl.clock_divisor = 8'h04;
    ctrl.word_done_irq_enable = 1'b1;
    ctrl.tx_dma_enable = 1'b1;
    ctrl.rx_dma_enable = 1'b1;
    ctrl.transmit_edge_select = 1'b1;
    sel_cfg = 3'b001;
    repeat (4) @(posedge clock);
    #2;
    reset_n = 1'b1;
    step(2);
    t_master(5'h08, 8, 1'b0, 32'h3a, 32'hc5);
    t_master(5'h08, 8, 1'b1, 32'h3a, 32'hc5);
    t_master(5'h00, 32, 1'b0, 32'h8421_f00d, 32'h5a3c_0ff1);
    t_queue();
    t_rxonly();
    t_slave();
    stop_test();
  end
endmodule
